//--- inc/link_ctrl_pkg.sv
// Shared constants and carrier types for the link behaviour control block
package link_ctrl_pkg;

    // Management register geometry
    localparam int             REG_AW         = 5;
    localparam int             REG_DW         = 16;
    localparam logic [4:0]     OFS_CTRL_A     = 5'h0a;
    localparam logic [4:0]     OFS_CTRL_B     = 5'h0b;
    localparam logic [15:0]    RST_CTRL_A     = 16'h0000;
    localparam logic [15:0]    RST_CTRL_B     = 16'h0000;

    // Field positions in control register A
    localparam int             BIT_EXT_FDX    = 5;
    localparam int             BIT_IDLE_SERR  = 2;
    localparam int             BIT_ODD_DIS    = 1;

    // Field positions in control register B
    localparam int             BIT_DSCR_FLD   = 10;

    // Writable bits; everything else is reserved
    localparam logic [15:0]    WMASK_CTRL_A   = 16'h0026;
    localparam logic [15:0]    WMASK_CTRL_B   = 16'h0400;

    // Management access request
    typedef struct packed {
        logic [4:0]  addr;
        logic        wr;
        logic        rd;
        logic [15:0] wdata;
    } reg_req_t;

    // One transmit nibble's control pair
    typedef struct packed {
        logic en;
        logic er;
    } mii_tx_t;

    // State of the odd-nibble guard
    typedef struct packed {
        mii_tx_t tx;
        logic    in_frame;
        logic    odd;
        logic    ext;
    } guard_state_t;

    // State of the control block
    typedef struct packed {
        logic [15:0] ctrl_a;
        logic [15:0] ctrl_b;
        logic [15:0] rdata;
        logic        full_duplex;
        logic        rx_er;
        logic        link_drop;
        logic        lock_d;
    } ctrl_state_t;

endpackage

//--- hdl/odd_nibble_guard.sv
// Transmit odd-nibble boundary guard with one-nibble extension
`timescale 1ns/100ps
module odd_nibble_guard
    import link_ctrl_pkg::*;
(
    input  wire logic    clk_in,
    input  wire logic    rst_n_in,
    input  wire logic    nib_stb_in,
    input  wire mii_tx_t tx_in,
    input  wire logic    detect_dis_in,
    output mii_tx_t      tx_out
);

    guard_state_t s_r;
    guard_state_t s_nxt;

    // Advance once per transmit clock period, marked by the nibble strobe
    always_comb begin
        s_nxt = s_r;
        if (nib_stb_in) begin
            s_nxt.ext = 1'b0;
            if (tx_in.en) begin
                s_nxt.in_frame = 1'b1;
                s_nxt.odd      = s_r.in_frame ? ~s_r.odd : 1'b1;
                s_nxt.tx       = tx_in;
            end else if (s_r.in_frame && s_r.odd && !detect_dis_in) begin
                // Frame ended mid-byte: hold enable one more nibble as an error
                s_nxt.in_frame = 1'b0;
                s_nxt.odd      = 1'b0;
                s_nxt.ext      = 1'b1;              // (R04)
                s_nxt.tx.en    = 1'b1;              // (R04)
                s_nxt.tx.er    = 1'b1;              // (R04)
            end else begin
                // Disabled check passes the drop straight through
                s_nxt.in_frame = 1'b0;
                s_nxt.odd      = 1'b0;
                s_nxt.tx       = tx_in;             // (R05)
            end
        end
    end

    // State register
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign tx_out = s_r.tx;

endmodule

//--- hdl/phy_link_behaviour_control.sv
// Link behaviour control registers and the corner-case logic they steer
`timescale 1ns/100ps
//
// Operation
// (R01) Override clear: duplex follows the standard resolution result.
// (R02) Override set, local AN or forced 100TX, partner forced 100TX: full duplex.
// (R03) Idle symbol errors reported only while the idle report bit is set.
// (R04) Odd-nibble enable drop extends enable one nibble, flagged as transmit error.
// (R05) Odd-nibble check disabled: no extension, no injected error.
// (R06) Descrambler drop works alongside the other fast link drop sources.
// (R07) Descrambler drop bit set: lock loss drops link; clear: it does not.
// (R08) Control register A at offset 0xA, resets to zero.
// (R09) Control register B at offset 0xB, resets to zero.
// (R10) Reserved bits read zero and ignore writes.
module phy_link_behaviour_control
    import link_ctrl_pkg::*;
(
    input  wire logic        CORE_CLK_IN,
    input  wire logic        RST_N_IN,
    // Management register port
    input  wire logic [4:0]  REG_ADDR_IN,
    input  wire logic        REG_WR_IN,
    input  wire logic        REG_RD_IN,
    input  wire logic [15:0] REG_WDATA_IN,
    output logic      [15:0] REG_RDATA_OUT,
    // Duplex resolution inputs
    input  wire logic        AN_ENABLE_IN,
    input  wire logic        FORCE_100TX_IN,
    input  wire logic        PARTNER_FORCED_100TX_IN,
    input  wire logic        STD_FULL_DUPLEX_IN,
    output logic             FULL_DUPLEX_OUT,
    // Receive error path
    input  wire logic        RX_FRAME_ERR_IN,
    input  wire logic        RX_IDLE_IN,
    input  wire logic        RX_SYM_ERR_IN,
    output logic             RX_ER_OUT,
    // Transmit control from the MAC side
    input  wire logic        TX_NIB_STB_IN,
    input  wire logic        TX_EN_IN,
    input  wire logic        TX_ER_IN,
    output logic             TX_EN_OUT,
    output logic             TX_ER_OUT,
    // Fast link drop
    input  wire logic        DSCR_LOCK_IN,
    input  wire logic        OTHER_FLD_IN,
    output logic             LINK_DROP_OUT,
    // Live option bits for the rest of the PHY
    output logic             IDLE_SYMBOL_ERROR_REPORT_OUT,
    output logic             DSCR_FLD_EN_OUT
);

    // Whole block state and its next value
    ctrl_state_t s_r;
    ctrl_state_t s_nxt;

    // Carriers and decoded conditions
    reg_req_t    req;
    mii_tx_t     tx_raw;
    mii_tx_t     tx_guarded;
    logic        forced_partner_case;
    logic        lock_lost;

    // Masked register update; reserved bits never take a one
    function automatic logic [15:0] masked_write(input logic [15:0] data,
                                                 input logic [15:0] mask);
        masked_write = data & mask;                 // (R10)
    endfunction

    // Index decode shared by the write and the read path
    function automatic logic [1:0] reg_select(input logic [4:0] addr);
        // No hit unless one of the two offsets matches
        reg_select = 2'h0;
        if (addr == OFS_CTRL_A) begin
            reg_select = 2'h1;
        end else if (addr == OFS_CTRL_B) begin
            reg_select = 2'h2;
        end
    endfunction

    // Duplex pick: the override only counts in the forced-partner case
    function automatic logic duplex_pick(input logic override_en,
                                         input logic forced_case,
                                         input logic std_full);
        if (override_en && forced_case) begin
            duplex_pick = 1'b1;                     // (R02)
        end else begin
            duplex_pick = std_full;                 // (R01)
        end
    endfunction

    // In-frame errors always pass; idle ones only while reporting is on
    function automatic logic rx_error_pick(input logic frame_err,
                                           input logic idle,
                                           input logic sym_err,
                                           input logic report_en);
        rx_error_pick = frame_err || (idle && sym_err && report_en); // (R03)
    endfunction

    // Descrambler drop is ORed in, so the other sources never mask it
    function automatic logic drop_pick(input logic other_req,
                                       input logic dscr_en,
                                       input logic lost);
        drop_pick = other_req || (dscr_en && lost);  // (R06) (R07)
    endfunction

    // Gather the request into its carrier
    assign req.addr  = REG_ADDR_IN;
    assign req.wr    = REG_WR_IN;
    assign req.rd    = REG_RD_IN;
    assign req.wdata = REG_WDATA_IN;

    // Local AN or local forced 100TX, with the partner in forced 100TX
    assign forced_partner_case = (AN_ENABLE_IN || FORCE_100TX_IN)
                               && PARTNER_FORCED_100TX_IN;

    // Lock fell since last cycle; the lock flag comes from same-clock logic
    assign lock_lost = s_r.lock_d && !DSCR_LOCK_IN;

    // Next-state logic for registers and derived outputs
    always_comb begin
        // Anything not named below holds its value
        s_nxt = s_r;

        // Register writes; write and read may share a cycle
        // A read in the same cycle still returns the old value
        if (req.wr) begin
            unique case (reg_select(req.addr))
                2'h1: begin
                    s_nxt.ctrl_a = masked_write(req.wdata, WMASK_CTRL_A); // (R08)
                end
                2'h2: begin
                    s_nxt.ctrl_b = masked_write(req.wdata, WMASK_CTRL_B); // (R09)
                end
                default: begin
                    // Unmapped index: the write is dropped
                    s_nxt.ctrl_a = s_r.ctrl_a;
                end
            endcase
        end

        // Read data shows stored value; other offsets read zero
        if (req.rd) begin
            unique case (reg_select(req.addr))
                2'h1: begin
                    s_nxt.rdata = s_r.ctrl_a & WMASK_CTRL_A;   // (R10)
                end
                2'h2: begin
                    s_nxt.rdata = s_r.ctrl_b & WMASK_CTRL_B;   // (R10)
                end
                default: begin
                    // Unmapped indexes read as zero
                    s_nxt.rdata = 16'h0000;
                end
            endcase
        end

        // Duplex decision from the override bit and both modes
        s_nxt.full_duplex = duplex_pick(s_r.ctrl_a[BIT_EXT_FDX],
                                        forced_partner_case,
                                        STD_FULL_DUPLEX_IN);    // (R01) (R02)

        // Receive error towards the MAC
        s_nxt.rx_er = rx_error_pick(RX_FRAME_ERR_IN, RX_IDLE_IN, RX_SYM_ERR_IN,
                                    s_r.ctrl_a[BIT_IDLE_SERR]); // (R03)

        // Fast link drop from every enabled source
        s_nxt.link_drop = drop_pick(OTHER_FLD_IN,
                                    s_r.ctrl_b[BIT_DSCR_FLD],
                                    lock_lost);                 // (R06) (R07)

        // Lock history; resets low so an unlocked receiver shows no false loss
        s_nxt.lock_d = DSCR_LOCK_IN;
    end

    // State register; both controls come up all zero
    always_ff @(posedge CORE_CLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            // Options come up off
            s_r.ctrl_a      <= RST_CTRL_A;          // (R08)
            s_r.ctrl_b      <= RST_CTRL_B;          // (R09)
            // Read data and decisions start quiet
            s_r.rdata       <= 16'h0000;
            s_r.full_duplex <= 1'b0;
            s_r.rx_er       <= 1'b0;
            s_r.link_drop   <= 1'b0;
            s_r.lock_d      <= 1'b0;
        end else begin
            s_r <= s_nxt;
        end
    end

    // Transmit path through the odd-nibble guard
    // Enable and error only move on strobe edges, so each stands a nibble
    assign tx_raw.en = TX_EN_IN;
    assign tx_raw.er = TX_ER_IN;

    odd_nibble_guard u_guard (
        .clk_in        (CORE_CLK_IN),
        .rst_n_in      (RST_N_IN),
        .nib_stb_in    (TX_NIB_STB_IN),
        .tx_in         (tx_raw),
        .detect_dis_in (s_r.ctrl_a[BIT_ODD_DIS]),  // (R05)
        .tx_out        (tx_guarded)
    );

    // Register read data holds until the next read
    assign REG_RDATA_OUT                = s_r.rdata;

    // Link decisions, one cycle behind their inputs
    assign FULL_DUPLEX_OUT              = s_r.full_duplex;
    assign RX_ER_OUT                    = s_r.rx_er;
    assign LINK_DROP_OUT                = s_r.link_drop;

    // Guarded transmit controls, moving only after a nibble strobe
    assign TX_EN_OUT                    = tx_guarded.en;
    assign TX_ER_OUT                    = tx_guarded.er;

    // Live option bits straight from the registers
    assign IDLE_SYMBOL_ERROR_REPORT_OUT = s_r.ctrl_a[BIT_IDLE_SERR];
    assign DSCR_FLD_EN_OUT              = s_r.ctrl_b[BIT_DSCR_FLD];

endmodule

//--- bench/mac_tx_model.sv
// Behavioural MAC transmit side: one nibble strobe every four clocks
`timescale 1ns/100ps
module mac_tx_model (
    input  wire logic       clk_in,
    input  wire logic       rst_n_in,
    input  wire logic       start_in,
    input  wire logic [3:0] len_in,
    output logic            stb_out,
    output logic            en_out,
    output logic            er_out
);
    logic [1:0] div_r;
    logic [3:0] left_r;
    // Enable moves only on a strobe edge, so it stands for the whole nibble
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            div_r  <= 2'h0;
            left_r <= 4'h0;
            en_out <= 1'b0;
        end else begin
            div_r <= div_r + 2'h1;
            if (start_in) left_r <= len_in;
            else if (stb_out && left_r != 4'h0) left_r <= left_r - 4'h1;
            if (stb_out) en_out <= left_r != 4'h0;
        end
    end
    // Clean frames only, so any error marking comes from the block
    assign stb_out = div_r == 2'h3;
    assign er_out  = 1'b0;
endmodule

//--- bench/link_ctrl_sva.sv
// Port-level assertions for the link behaviour control block
`timescale 1ns/100ps
module link_ctrl_checker
    import link_ctrl_pkg::*;
(
    input wire logic CORE_CLK_IN, RST_N_IN, REG_WR_IN, REG_RD_IN, TX_NIB_STB_IN, TX_EN_IN,
    input wire logic AN_ENABLE_IN, FORCE_100TX_IN, PARTNER_FORCED_100TX_IN, STD_FULL_DUPLEX_IN,
    input wire logic RX_FRAME_ERR_IN, RX_IDLE_IN, RX_SYM_ERR_IN, DSCR_LOCK_IN, OTHER_FLD_IN,
    input wire logic FULL_DUPLEX_OUT, RX_ER_OUT, TX_EN_OUT, TX_ER_OUT, TX_ER_IN, LINK_DROP_OUT,
    input wire logic IDLE_SYMBOL_ERROR_REPORT_OUT, DSCR_FLD_EN_OUT,
    input wire logic [4:0]  REG_ADDR_IN,
    input wire logic [15:0] REG_WDATA_IN, REG_RDATA_OUT
);
    logic [15:0] sh_a, sh_b;
    logic        odd;
    // Own shadow of the options, so expectations never lean on design state
    always_ff @(posedge CORE_CLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            sh_a <= 16'h0000;
            sh_b <= 16'h0000;
            odd  <= 1'b0;
        end else begin
            if (REG_WR_IN && REG_ADDR_IN == OFS_CTRL_A) sh_a <= REG_WDATA_IN & WMASK_CTRL_A;
            if (REG_WR_IN && REG_ADDR_IN == OFS_CTRL_B) sh_b <= REG_WDATA_IN & WMASK_CTRL_B;
            if (TX_NIB_STB_IN) odd <= TX_EN_IN & ~odd;
        end
    end
    // Expected values one cycle ahead of the registered outputs
    wire idle_err = RX_IDLE_IN & RX_SYM_ERR_IN & ~RX_FRAME_ERR_IN;
    wire dup_exp = STD_FULL_DUPLEX_IN
        | sh_a[5] & (AN_ENABLE_IN | FORCE_100TX_IN) & PARTNER_FORCED_100TX_IN;
    wire [15:0] rd_exp = REG_ADDR_IN == OFS_CTRL_A ? sh_a
        : REG_ADDR_IN == OFS_CTRL_B ? sh_b : 16'h0000;
    default clocking @(posedge CORE_CLK_IN); endclocking
    default disable iff (!RST_N_IN);
    sequence s_odd_drop;
        TX_NIB_STB_IN && !TX_EN_IN && odd;
    endsequence
    a_duplex_choice: assert property (
        $past(RST_N_IN) |-> FULL_DUPLEX_OUT == $past(dup_exp)) else $error("duplex wrong");
    a_idle_report: assert property (
        $past(idle_err) |-> RX_ER_OUT == $past(sh_a[2])) else $error("idle report wrong");
    a_odd_extend: assert property (
        s_odd_drop ##0 !sh_a[1] |=> TX_EN_OUT && TX_ER_OUT) else $error("no extension");
    a_odd_skip: assert property (
        s_odd_drop ##0 sh_a[1] |=> !TX_EN_OUT && TX_ER_OUT == $past(TX_ER_IN))
        else $error("unwanted extension");
    a_lock_drop: assert property (
        $past(RST_N_IN, 2) && $past(DSCR_LOCK_IN, 2) && !$past(DSCR_LOCK_IN)
        && $past(sh_b[10]) |-> LINK_DROP_OUT) else $error("lock loss not dropped");
    a_no_drop: assert property (
        !$past(OTHER_FLD_IN) && !$past(sh_b[10]) |-> !LINK_DROP_OUT) else $error("stray drop");
    a_option_live: assert property (
        IDLE_SYMBOL_ERROR_REPORT_OUT == sh_a[2] && DSCR_FLD_EN_OUT == sh_b[10])
        else $error("option outputs wrong");
    a_read_data: assert property (
        REG_RD_IN |=> REG_RDATA_OUT == $past(rd_exp)) else $error("read data wrong");
endmodule
bind phy_link_behaviour_control link_ctrl_checker u_chk (.*);

//--- bench/phy_link_behaviour_control_bench.sv
// Self-checking bench for the link behaviour control block
`timescale 1ns/100ps
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin errors++; \
    $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e); end end
module phy_link_behaviour_control_bench;
    import link_ctrl_pkg::*;
    logic CORE_CLK_IN, RST_N_IN, REG_WR_IN, REG_RD_IN, AN_ENABLE_IN, FORCE_100TX_IN, start;
    logic PARTNER_FORCED_100TX_IN, STD_FULL_DUPLEX_IN, RX_IDLE_IN, RX_SYM_ERR_IN;
    logic RX_FRAME_ERR_IN, OTHER_FLD_IN, DSCR_LOCK_IN;
    logic [3:0] len;
    logic [4:0] REG_ADDR_IN;
    logic [15:0] REG_WDATA_IN, v;
    wire [15:0] REG_RDATA_OUT;
    wire FULL_DUPLEX_OUT, RX_ER_OUT, TX_NIB_STB_IN, TX_EN_IN, TX_ER_IN, TX_EN_OUT, TX_ER_OUT;
    wire LINK_DROP_OUT, IDLE_SYMBOL_ERROR_REPORT_OUT, DSCR_FLD_EN_OUT;
    int errors, check_count;
    // Narrow logic counters so an unknown output cannot slip through as zero
    logic [7:0] ne, nr;
    // A written, A read, {an,f100,pf,std,idle,serr,ferr,other}, {fd,rxer,drop}
    logic [42:0] rows [9] = '{
        {16'h0000, 16'h0000, 8'ha0, 3'h0}, {16'h0020, 16'h0020, 8'ha0, 3'h4},
        {16'h0020, 16'h0020, 8'h60, 3'h4}, {16'h0020, 16'h0020, 8'h80, 3'h0},
        {16'h0004, 16'h0004, 8'h0c, 3'h2}, {16'h0000, 16'h0000, 8'h0c, 3'h0},
        {16'h0000, 16'h0000, 8'h02, 3'h2}, {16'h0000, 16'h0000, 8'h01, 3'h1},
        {16'hffff, 16'h0026, 8'h10, 3'h4}};
    mac_tx_model u_mac (.clk_in(CORE_CLK_IN), .rst_n_in(RST_N_IN), .start_in(start),
        .len_in(len), .stb_out(TX_NIB_STB_IN), .en_out(TX_EN_IN), .er_out(TX_ER_IN));
    phy_link_behaviour_control u_dut (.*);
    initial begin
        CORE_CLK_IN = 0;
        forever #5 CORE_CLK_IN = ~CORE_CLK_IN;
    end
    task automatic drv(input logic [7:0] x);
        {AN_ENABLE_IN, FORCE_100TX_IN, PARTNER_FORCED_100TX_IN, STD_FULL_DUPLEX_IN,
         RX_IDLE_IN, RX_SYM_ERR_IN, RX_FRAME_ERR_IN, OTHER_FLD_IN} = x;
    endtask
    // Register cycles: one strobe cycle each, entered just after an edge;
    // a read leaves one idle edge so two reads never touch the strobe twice
    task automatic wr(input logic [4:0] a, input logic [15:0] d);
        REG_ADDR_IN = a; REG_WDATA_IN = d; REG_WR_IN = 1;
        @(posedge CORE_CLK_IN); #1 REG_WR_IN = 0;
    endtask
    task automatic rd(input logic [4:0] a, output logic [15:0] d);
        REG_ADDR_IN = a; REG_RD_IN = 1;
        @(posedge CORE_CLK_IN); #1 REG_RD_IN = 0; d = REG_RDATA_OUT;
        @(posedge CORE_CLK_IN); #1;
    endtask
    task automatic loss(input logic e);
        DSCR_LOCK_IN = 1; repeat (2) @(posedge CORE_CLK_IN); #1 DSCR_LOCK_IN = 0;
        @(posedge CORE_CLK_IN); #1 `CHK(LINK_DROP_OUT, e)
        @(posedge CORE_CLK_IN); #1 `CHK(LINK_DROP_OUT, 1'b0)
    endtask
    // Counts cycles of enable and error over one whole frame and its tail
    task automatic tx(input logic [15:0] a, input logic [3:0] n, input int en, er);
        wr(OFS_CTRL_A, a); len = n; start = 1;
        @(posedge CORE_CLK_IN); #1 start = 0; ne = 0; nr = 0;
        repeat (60) begin
            @(posedge CORE_CLK_IN); #1 ne += TX_EN_OUT; nr += TX_ER_OUT;
        end
        `CHK(ne, en)
        `CHK(nr, er)
    endtask
    task automatic results;
        $display("checks=%0d mismatches=%0d", check_count, errors);
        if (errors == 0 && check_count > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    initial begin
        {RST_N_IN, REG_WR_IN, REG_RD_IN, DSCR_LOCK_IN, start, len} = '0;
        REG_ADDR_IN = 5'h00; REG_WDATA_IN = 16'h0000; drv(8'h00);
        repeat (2) @(posedge CORE_CLK_IN); #1 RST_N_IN = 1;
        rd(OFS_CTRL_A, v); `CHK(v, 16'h0000)
        rd(OFS_CTRL_B, v); `CHK(v, 16'h0000)
        wr(OFS_CTRL_B, 16'hffff); rd(OFS_CTRL_B, v); `CHK(v, 16'h0400)
        `CHK(DSCR_FLD_EN_OUT, 1'b1)
        wr(5'h0c, 16'hffff); rd(5'h0c, v); `CHK(v, 16'h0000)
        $display("registers done");
        loss(1'b1);
        wr(OFS_CTRL_B, 16'h0000); loss(1'b0);
        $display("lock drop done");
        foreach (rows[i]) begin
            wr(OFS_CTRL_A, rows[i][42:27]); drv(rows[i][10:3]);
            @(posedge CORE_CLK_IN); #1;
            `CHK({FULL_DUPLEX_OUT, RX_ER_OUT, LINK_DROP_OUT}, rows[i][2:0])
            rd(OFS_CTRL_A, v); `CHK(v, rows[i][26:11])
        end
        drv(8'h00); $display("rows done");
        tx(16'h0000, 4'h3, 16, 4);
        tx(16'h0002, 4'h3, 12, 0);
        tx(16'h0000, 4'h2, 8, 0);
        $display("transmit done");
        // Reset in mid-run must clear options and read data
        wr(OFS_CTRL_A, 16'hffff); rd(OFS_CTRL_A, v); `CHK(v, 16'h0026)
        wr(OFS_CTRL_B, 16'hffff);
        `CHK({IDLE_SYMBOL_ERROR_REPORT_OUT, DSCR_FLD_EN_OUT}, 2'h3)
        RST_N_IN = 0; repeat (2) @(posedge CORE_CLK_IN); #1;
        `CHK({IDLE_SYMBOL_ERROR_REPORT_OUT, DSCR_FLD_EN_OUT}, 2'h0)
        `CHK(REG_RDATA_OUT, 16'h0000)
        RST_N_IN = 1; rd(OFS_CTRL_A, v); `CHK(v, 16'h0000)
        rd(OFS_CTRL_B, v); `CHK(v, 16'h0000)
        $display("reset done");
        results();
    end
    // Hang guard: an overrun counts against the run
    initial begin
        #50000 errors++;
        results();
    end
endmodule
